// ===== dfp_fault_protect.sv
// Function
// - Overcurrent comparator sets flag pin and latch
// - Overcurrent latch in status, masked interrupt
// - Overcurrent interrupt holds until gone and cleared
// - High side on only after deadtime
// - Desat initiated after blanking below margin
// - Desat valid after one microsecond filter
// - Registered desat turns every driver off
// - Desat vanishing restarts filter from zero
// - Valid faults recorded in readable status
// - Masks and shutdown disables for desat/phase
// - High-side error: commanded on, node low
// - Low-side error: commanded on, node high
// - Phase errors ORed per phase and overall
// - Phase interrupt holds until gone and cleared
// - Undervoltage drives gates off eight microseconds
// - Undervoltage detection filtered 700 nanoseconds
// - Recovery: low follows, high needs init
// - High side floats until low turns off
// - Hold-off pulls gates low on conditions
// - After fault, re-init low then high
// - Clear command bits clear matching latches
// - Mask command bits enable interrupts
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "dfp_consts.svh"
module dfp_fault_protect #(
   parameter int UV_DRIVE_CYC = `DFP_UV_DRIVE_CYC,
   parameter int PHASES       = 3
) (
   input  wire logic              core_clk_in,
   input  wire logic              reset_n_in,
   // Register port
   input  wire logic [3:0]        addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [7:0]        rdata_out,
   // Pins from outside the clock domain
   input  wire logic              oc_comp_in,
   input  wire logic              supply_ok_in,
   input  wire logic              gate_supply_low_in,
   input  wire logic [PHASES-1:0] high_cmd_in,
   input  wire logic [PHASES-1:0] low_cmd_in,
   input  wire logic [PHASES-1:0] desat_in,
   input  wire logic [PHASES-1:0] phase_node_in,
   // Outputs
   output logic                   overcurrent_flag_out,
   output logic                   irq_out,
   output logic      [PHASES-1:0] high_gate_out,
   output logic      [PHASES-1:0] high_gate_oe_out,
   output logic      [PHASES-1:0] low_gate_out,
   output logic      [PHASES-1:0] active_off_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [3:0] A_STATUS  = 4'h0;  // Fault latches, read
   localparam logic [3:0] A_MASK_A  = 4'h1;  // Interrupt mask bits [3:0]
   localparam logic [3:0] A_MASK_B  = 4'h2;  // Shutdown disables [1:0]
   localparam logic [3:0] A_CLEAR_A = 4'h3;  // Clear-latch command a
   localparam logic [3:0] A_CLEAR_B = 4'h4;  // Clear-latch command b
   localparam logic [3:0] A_DEAD    = 4'h5;  // Deadtime in cycles
   localparam logic [3:0] A_LIVE    = 4'h6;  // Live conditions and mode, read

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   localparam int NS = 3 + 4 * PHASES;
   logic [NS-1:0] sync_a;                 // First stage, read by second only
   logic [NS-1:0] sync_b;                 // Second stage, usable
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {oc_comp_in, supply_ok_in, gate_supply_low_in,
                    high_cmd_in, low_cmd_in, desat_in, phase_node_in};
         sync_b <= sync_a;
      end
   end
   wire              oc_s   = sync_b[NS-1];
   wire              sup_s  = sync_b[NS-2];
   wire              uvr_s  = sync_b[NS-3];
   wire [PHASES-1:0] hcmd_s = sync_b[4*PHASES-1:3*PHASES];
   wire [PHASES-1:0] lcmd_s = sync_b[3*PHASES-1:2*PHASES];
   wire [PHASES-1:0] des_s  = sync_b[2*PHASES-1:PHASES];
   wire [PHASES-1:0] node_s = sync_b[PHASES-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Software-visible state
   logic [3:0] irq_mask;                  // Interrupt enables
   logic [1:0] sd_disable;                // [0] desat, [1] phase shutdown off
   logic [3:0] fault;                     // Sticky fault latches
   logic [7:0] deadtime;                  // Deadtime in cycles
   wire wr_mask_a  = wr_in && addr_in == A_MASK_A;
   wire wr_mask_b  = wr_in && addr_in == A_MASK_B;
   wire wr_clr_a   = wr_in && addr_in == A_CLEAR_A;
   wire wr_clr_b   = wr_in && addr_in == A_CLEAR_B;
   wire wr_dead    = wr_in && addr_in == A_DEAD;

   ////////////////////////////////////////////////////////////////////////////////
   // Undervoltage filter and active drive-off timers
   logic [9:0]  uv_filt;                  // Filter counter
   logic        uv;                       // Filtered undervoltage
   logic [15:0] uv_drive;                 // Active drive-off remaining
   wire         uv_fall = uvr_s && !uv && uv_filt == 10'(`DFP_UV_FILT_CYC - 1);
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         uv_filt  <= '0;
         uv       <= 1'b0;
         uv_drive <= '0;
      end
      else
      begin
         // Count continuous low supply before acting
         if (!uvr_s)
            uv_filt <= '0;
         else if (!uv)
            uv_filt <= uv_filt + 10'h001;
         if (uv_fall)
            uv <= 1'b1;
         else if (!uvr_s)
            uv <= 1'b0;                   // Recovery is immediate
         // Active drive-off window, then weak hold-off
         if (uv_fall)
            uv_drive <= 16'(UV_DRIVE_CYC);
         else if (uv_drive != '0)
            uv_drive <= uv_drive - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode and initialisation tracking
   dfp_pkg::dfp_mode_t mode;
   logic               low_toggled;       // Low side seen toggled since init
   logic [PHASES-1:0]  lcmd_d;            // Low command, last cycle
   logic [PHASES-1:0]  hcmd_d;            // High command, last cycle
   wire  [PHASES-1:0]  low_edge  = lcmd_s ^ lcmd_d;
   wire  [PHASES-1:0]  high_edge = hcmd_s ^ hcmd_d;
   logic               desat_trip;        // Registered desat with shutdown
   logic               phase_trip;        // Phase error with shutdown
   wire  hold_off  = !sup_s || uv;
   wire  protect_e = desat_trip || phase_trip || uv;
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         mode        <= dfp_pkg::DFP_INIT;
         low_toggled <= 1'b0;
         lcmd_d      <= '0;
         hcmd_d      <= '0;
      end
      else
      begin
         lcmd_d <= lcmd_s;
         hcmd_d <= hcmd_s;
         unique case (mode)
            // Low then high toggle completes initialisation
            dfp_pkg::DFP_INIT:
            begin
               if (protect_e)
                  mode <= dfp_pkg::DFP_PROTECT;
               else if (low_toggled && high_edge != '0)
                  mode <= dfp_pkg::DFP_ENABLED;
               if (low_edge != '0)
                  low_toggled <= 1'b1;
            end
            dfp_pkg::DFP_ENABLED:
               if (protect_e)
                  mode <= dfp_pkg::DFP_PROTECT;
            // Wait for the fault to clear, then demand re-init
            dfp_pkg::DFP_PROTECT:
               if (!protect_e)
               begin
                  mode        <= dfp_pkg::DFP_INIT;
                  low_toggled <= 1'b0;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-phase deadtime, blanking, desat filter and phase checks
   dfp_pkg::dfp_phase_t pst   [PHASES];
   logic [7:0]          dcnt  [PHASES];   // Deadtime counter
   logic [7:0]          bcnt  [PHASES];   // Blanking counter
   logic [6:0]          fcnt  [PHASES];   // Desat filter counter
   logic [PHASES-1:0]   desat_valid;      // Filtered desat per phase
   logic [PHASES-1:0]   hs_err;
   logic [PHASES-1:0]   ls_err;
   logic [PHASES-1:0]   hs_armed;         // High side allowed after recovery
   wire  [PHASES-1:0]   ph_err = hs_err | ls_err;
   wire                 phase_flag = |ph_err;
   wire                 desat_flag = |desat_valid;
   for (genvar p = 0; p < PHASES; p++)
   begin : g_ph
      wire blank_done = bcnt[p] == 8'(`DFP_BLANK_CYC);
      always_ff @(posedge core_clk_in or negedge reset_n_in)
      begin
         if (!reset_n_in)
         begin
            pst[p]         <= dfp_pkg::DFP_OFF;
            dcnt[p]        <= '0;
            bcnt[p]        <= '0;
            fcnt[p]        <= '0;
            desat_valid[p] <= 1'b0;
            hs_err[p]      <= 1'b0;
            ls_err[p]      <= 1'b0;
            hs_armed[p]    <= 1'b0;
         end
         else
         begin
            // Leading edges pick the side; deadtime before high on
            unique case (pst[p])
               dfp_pkg::DFP_OFF, dfp_pkg::DFP_LOW_ON:
                  if (hcmd_s[p] && high_edge[p])
                  begin
                     pst[p]  <= dfp_pkg::DFP_DEAD_TO_HIGH;
                     dcnt[p] <= '0;
                  end
                  else if (lcmd_s[p])
                     pst[p] <= dfp_pkg::DFP_LOW_ON;
                  else
                     pst[p] <= dfp_pkg::DFP_OFF;
               dfp_pkg::DFP_DEAD_TO_HIGH:
                  if (!hcmd_s[p])
                     pst[p] <= dfp_pkg::DFP_OFF;
                  else if (dcnt[p] >= deadtime)
                     pst[p] <= dfp_pkg::DFP_HIGH_ON;
                  else
                     dcnt[p] <= dcnt[p] + 8'h01;
               dfp_pkg::DFP_HIGH_ON:
                  if (lcmd_s[p] && low_edge[p])
                     pst[p] <= dfp_pkg::DFP_LOW_ON;
                  else if (!hcmd_s[p])
                     pst[p] <= dfp_pkg::DFP_OFF;
            endcase
            // Blanking counts from the on state of either side
            if (pst[p] == dfp_pkg::DFP_HIGH_ON || pst[p] == dfp_pkg::DFP_LOW_ON)
            begin
               if (!blank_done)
                  bcnt[p] <= bcnt[p] + 8'h01;
            end
            else
               bcnt[p] <= '0;
            // Desat filter restarts when condition drops
            if (pst[p] == dfp_pkg::DFP_HIGH_ON && blank_done && des_s[p])
            begin
               if (fcnt[p] == 7'(`DFP_DESAT_FILT_CYC - 1))
                  desat_valid[p] <= 1'b1;
               else
                  fcnt[p] <= fcnt[p] + 7'h01;
            end
            else
            begin
               fcnt[p]        <= '0;
               desat_valid[p] <= 1'b0;
            end
            // Phase node checks after blanking, the high side after deadtime plus blanking
            hs_err[p] <= pst[p] == dfp_pkg::DFP_HIGH_ON && blank_done && !node_s[p];
            ls_err[p] <= pst[p] == dfp_pkg::DFP_LOW_ON && blank_done && node_s[p];
            // High side floats until its low side turns off
            if (uv)
               hs_armed[p] <= 1'b0;
            else if (!lcmd_s[p] && low_edge[p])
               hs_armed[p] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fault latches, masks and configuration
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         fault      <= '0;
         irq_mask   <= '0;
         sd_disable <= '0;
         deadtime   <= `DFP_DEADTIME_RST;
         desat_trip <= 1'b0;
         phase_trip <= 1'b0;
      end
      else
      begin
         // Clear command a or b clears, a present fault sets again
         if (wr_clr_a)
            fault <= fault & ~wdata_in[3:0];
         if (wr_clr_b)
            fault <= fault & ~wdata_in[3:0];
         if (oc_s)
            fault[`DFP_BIT_OC] <= 1'b1;
         if (desat_flag)
            fault[`DFP_BIT_DESAT] <= 1'b1;
         if (phase_flag)
            fault[`DFP_BIT_PHASE] <= 1'b1;
         if (uv)
            fault[`DFP_BIT_UV] <= 1'b1;
         if (wr_mask_a)
            irq_mask <= wdata_in[3:0];
         if (wr_mask_b)
            sd_disable <= wdata_in[1:0];
         if (wr_dead)
            deadtime <= wdata_in;
         // Shutdown trips hold until the condition is gone
         desat_trip <= desat_flag && !sd_disable[0] ||
                       desat_trip && desat_flag;
         phase_trip <= phase_flag && !sd_disable[1] ||
                       phase_trip && phase_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gate drive outputs and readback
   wire run     = mode != dfp_pkg::DFP_PROTECT && !protect_e && !hold_off;
   wire [PHASES-1:0] next_low;
   wire [PHASES-1:0] next_high;
   // Low follows input on recovery, high needs init
   assign next_low  = run ? lcmd_s & low_allow() : '0;
   assign next_high = (run && mode == dfp_pkg::DFP_ENABLED) ? high_on_vec() : '0;
   // Low side held off while its high side waits out deadtime or conducts
   function automatic logic [PHASES-1:0] low_allow();
      logic [PHASES-1:0] v;
      v = '0;
      for (int i = 0; i < PHASES; i++)
         v[i] = pst[i] != dfp_pkg::DFP_DEAD_TO_HIGH && pst[i] != dfp_pkg::DFP_HIGH_ON;
      return v;
   endfunction
   function automatic logic [PHASES-1:0] high_on_vec();
      logic [PHASES-1:0] v;
      v = '0;
      for (int i = 0; i < PHASES; i++)
         v[i] = pst[i] == dfp_pkg::DFP_HIGH_ON && hs_armed[i];
      return v;
   endfunction
   wire [7:0] next_rdata =
      addr_in == A_STATUS ? {4'h0, fault} :
      addr_in == A_MASK_A ? {4'h0, irq_mask} :
      addr_in == A_MASK_B ? {6'h00, sd_disable} :
      addr_in == A_DEAD   ? deadtime :
      addr_in == A_LIVE   ? {mode, hold_off, uv, oc_s, phase_flag, desat_flag, 1'b0} :
      8'h00;
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         low_gate_out         <= '0;
         high_gate_out        <= '0;
         high_gate_oe_out     <= '0;
         active_off_out       <= '0;
         overcurrent_flag_out <= 1'b0;
         irq_out              <= 1'b0;
         rdata_out            <= '0;
      end
      else
      begin
         low_gate_out     <= next_low;
         high_gate_out    <= next_high;
         high_gate_oe_out <= hs_armed & {PHASES{!(hold_off && uv_drive == '0)}};
         // Strong drive-off in the timed window or while a shutdown trip holds, weak hold-off after
         active_off_out   <= {PHASES{uv_drive != '0 || desat_trip || phase_trip}};
         overcurrent_flag_out <= oc_s;
         irq_out <= |(fault & irq_mask);
         rdata_out <= rd_in ? next_rdata : 8'h00;
      end
   end
endmodule // dfp_fault_protect

// ===== dfp_consts.svh
`ifndef DFP_CONSTS_SVH
`define DFP_CONSTS_SVH
// Oscillator rate and documented intervals
`define DFP_CLK_MHZ          100
`define DFP_PERIOD_NS        10
`define DFP_DESAT_FILT_NS    1000
`define DFP_UV_FILT_NS       700
`define DFP_UV_DRIVE_NS      8000
`define DFP_BLANK_NS         200
// Derived cycle counts (least times round up)
`define DFP_DESAT_FILT_CYC   ((`DFP_DESAT_FILT_NS + `DFP_PERIOD_NS - 1) / `DFP_PERIOD_NS)
`define DFP_UV_FILT_CYC      ((`DFP_UV_FILT_NS + `DFP_PERIOD_NS - 1) / `DFP_PERIOD_NS)
`define DFP_UV_DRIVE_CYC     ((`DFP_UV_DRIVE_NS + `DFP_PERIOD_NS - 1) / `DFP_PERIOD_NS)
`define DFP_BLANK_CYC        ((`DFP_BLANK_NS + `DFP_PERIOD_NS - 1) / `DFP_PERIOD_NS)
// Fault status bit positions
`define DFP_BIT_OC           0
`define DFP_BIT_DESAT        1
`define DFP_BIT_PHASE        2
`define DFP_BIT_UV           3
`define DFP_DEADTIME_RST     8'h05
`endif

// ===== dfp_pkg.sv
package dfp_pkg;
   // Per-phase gate sequencing states
   typedef enum logic [1:0] {
      DFP_OFF,
      DFP_DEAD_TO_HIGH,
      DFP_HIGH_ON,
      DFP_LOW_ON
   } dfp_phase_t;
   // Global operating mode
   typedef enum logic [1:0] {
      DFP_INIT,
      DFP_ENABLED,
      DFP_PROTECT
   } dfp_mode_t;
endpackage

// ===== dfp_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Host controller: register master and direct gate commands
module dfp_host_model (
   input  wire logic       clk_in,
   output logic      [3:0] addr_out,
   output logic      [7:0] wdata_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic      [2:0] high_cmd_out,
   output logic      [2:0] low_cmd_out
);
   // Idle bus and released commands at time zero
   initial {addr_out, wdata_out, wr_out, rd_out, high_cmd_out, low_cmd_out} = '0;
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_out    <= 1'b1;
      addr_out  <= a;
      wdata_out <= d;
      @(posedge clk_in);
      wr_out    <= 1'b0;
   endtask
   // One-cycle read strobe, data shows in the next cycle
   task automatic rd(input logic [3:0] a);
      @(posedge clk_in);
      rd_out   <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_out   <= 1'b0;
   endtask
   // New levels on the direct gate inputs
   task automatic cmd(input logic [2:0] h, input logic [2:0] l);
      @(posedge clk_in);
      high_cmd_out <= h;
      low_cmd_out  <= l;
   endtask
   // Low side pulse charges the bootstrap, then high side pulse
   task automatic init_seq();
      cmd(3'h0, 3'h7);
      repeat (15) @(posedge clk_in);
      cmd(3'h0, 3'h0);
      repeat (15) @(posedge clk_in);
      cmd(3'h7, 3'h0);
      repeat (15) @(posedge clk_in);
      cmd(3'h0, 3'h0);
      repeat (30) @(posedge clk_in);
   endtask
endmodule // dfp_host_model

// ===== dfp_monitor.sv
`timescale 1ns/1ps
module dfp_monitor #(
   parameter int UV_DRIVE_CYC = 800,
   parameter int PHASES       = 3
) (
   input wire logic              core_clk_in,
   input wire logic              reset_n_in,
   input wire logic [3:0]        addr_in,
   input wire logic [7:0]        wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [7:0]        rdata_out,
   input wire logic              oc_comp_in,
   input wire logic              supply_ok_in,
   input wire logic              gate_supply_low_in,
   input wire logic              overcurrent_flag_out,
   input wire logic              irq_out,
   input wire logic [PHASES-1:0] high_gate_out,
   input wire logic [PHASES-1:0] low_gate_out,
   input wire logic [PHASES-1:0] active_off_out
);
   logic        mask_oc; // Shadow of the overcurrent mask bit
   logic [7:0]  uv_cnt;  // Consecutive low gate supply cycles
   logic [15:0] ao_cnt;  // Consecutive strong drive-off cycles
   // Shadow registers and run counters
   always_ff @(posedge core_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         mask_oc <= 1'b0;
         uv_cnt  <= 8'h00;
         ao_cnt  <= 16'h0000;
      end
      else
      begin
         if (wr_in && addr_in == 4'h1)
            mask_oc <= wdata_in[0];
         uv_cnt <= !gate_supply_low_in ? 8'h00 : uv_cnt + {7'h0, uv_cnt != 8'hff};
         ao_cnt <= (|active_off_out) ? ao_cnt + 16'h0001 : 16'h0000;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   AST_OC_FOLLOW: assert property (oc_comp_in [*4] |-> overcurrent_flag_out)
      else $error("overcurrent flag not raised");
   AST_OC_DROP: assert property (!oc_comp_in [*4] |-> !overcurrent_flag_out)
      else $error("overcurrent flag not dropped");
   AST_OC_IRQ: assert property (mask_oc && overcurrent_flag_out |-> ##[0:3] irq_out)
      else $error("masked overcurrent gave no interrupt");
   AST_OC_HOLD: assert property (irq_out && mask_oc && overcurrent_flag_out |=> irq_out)
      else $error("interrupt dropped while overcurrent present");
   AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
      else $error("interrupt fell without a command");
   AST_NO_SHOOT: assert property ((high_gate_out & low_gate_out) == '0)
      else $error("both sides of a phase on");
   AST_DEAD: assert property ($rose(high_gate_out[0]) |-> !$past(low_gate_out[0], 2))
      else $error("high side on without dead gap");
   AST_HOLD_OFF: assert property (!supply_ok_in [*4] |-> high_gate_out == '0 && low_gate_out == '0)
      else $error("gates on with logic supply low");
   AST_UV_FILT: assert property ($rose(|active_off_out) && gate_supply_low_in |-> uv_cnt >= 8'h44)
      else $error("undervoltage acted before filter time");
   AST_UV_DRIVE: assert property ($fell(|active_off_out) && gate_supply_low_in |-> ao_cnt >= UV_DRIVE_CYC - 1 && ao_cnt <= UV_DRIVE_CYC + 1)
      else $error("strong drive-off length wrong");
   AST_AO_GATES: assert property (|active_off_out |-> high_gate_out == '0 && low_gate_out == '0)
      else $error("gate on during drive-off");
   AST_RDATA: assert property (!$past(rd_in) || $past(addr_in) > 4'h6 |-> rdata_out == 8'h00)
      else $error("read data outside its slot");
   // Main scenarios reached
   COV_IRQ: cover property (irq_out);
   COV_UV: cover property ($fell(|active_off_out));
   COV_HIGH: cover property ($rose(high_gate_out[0]));
endmodule // dfp_monitor
bind dfp_fault_protect dfp_monitor #(.UV_DRIVE_CYC(UV_DRIVE_CYC), .PHASES(PHASES)) u_mon (
   .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .oc_comp_in(oc_comp_in), .supply_ok_in(supply_ok_in),
   .gate_supply_low_in(gate_supply_low_in), .overcurrent_flag_out(overcurrent_flag_out),
   .irq_out(irq_out), .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
   .active_off_out(active_off_out));

// ===== tb.sv
`timescale 1ns/1ps
module tb;
   localparam int UV_CYC = 10;
   logic       core_clk_in = 1'b0;
   logic       reset_n_in  = 1'b0;
   logic       oc_comp     = 1'b0;
   logic       supply_ok   = 1'b1;
   logic       gs_low      = 1'b0;
   logic       rd_q        = 1'b0;
   logic [2:0] desat       = 3'h0;
   logic [2:0] force_m     = 3'h0; // Phase nodes held by a fault
   logic [2:0] force_v     = 3'h0;
   logic [2:0] node        = 3'h0;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, dt, rv;
   logic       wr, rd, oc_flag, irq;
   logic [2:0] hcmd, lcmd, hg, hoe, lg, ao;
   logic [7:0] exp_q[$];           // Expected read data
   int         n_errors     = 0;
   int         total_checks = 0;
   int         seed         = 32'h5148058c;
   int         n;
   always #5 core_clk_in = ~core_clk_in;
   // Bridge: node follows the high side unless a fault holds it
   always @(posedge core_clk_in)
      node <= (hg & ~force_m) | (force_m & force_v);
   dfp_host_model host (.clk_in(core_clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
      .rd_out(rd), .high_cmd_out(hcmd), .low_cmd_out(lcmd));
   dfp_fault_protect #(.UV_DRIVE_CYC(UV_CYC)) dut (.core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata), .oc_comp_in(oc_comp), .supply_ok_in(supply_ok),
      .gate_supply_low_in(gs_low), .high_cmd_in(hcmd), .low_cmd_in(lcmd), .desat_in(desat),
      .phase_node_in(node), .overcurrent_flag_out(oc_flag), .irq_out(irq),
      .high_gate_out(hg), .high_gate_oe_out(hoe), .low_gate_out(lg), .active_off_out(ao));
   ////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_in);
      @(negedge core_clk_in);
   endtask
   // Note the expectation, then read
   task automatic rx(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Read data compared in its one valid cycle
   always @(posedge core_clk_in)
      rd_q <= rd;
   always @(negedge core_clk_in)
      if (rd_q)
         check(rdata, exp_q.pop_front());
   // Watchdog
   initial
   begin
      #200000;
      n_errors++;
      tally_and_finish();
   end
   ////////////////////////////////////////
   initial
   begin
      cyc(12);
      reset_n_in <= 1'b1;
      check({2'h0, hg, lg}, 8'h00);
      rx(4'h0, 8'h00);
      rx(4'h5, 8'h05);
      rx(4'h6, 8'h00);
      host.wr(4'h7, 8'hff);
      rx(4'h7, 8'h00);
      repeat (4)
      begin
         rv = 8'($random(seed));
         dt = 8'h02 + {5'h0, rv[2:0]};
         host.wr(4'h1, rv);
         host.wr(4'h2, rv);
         host.wr(4'h5, dt);
         rx(4'h1, {4'h0, rv[3:0]});
         rx(4'h2, {6'h0, rv[1:0]});
         rx(4'h5, dt);
      end
      host.wr(4'h1, 8'h00);
      host.wr(4'h2, 8'h00);
      $display("test registers done");
      // Overcurrent latch, mask and clear
      oc_comp <= 1'b1;
      cyc(6);
      check(8'(oc_flag), 8'h01);
      check(8'(irq), 8'h00);
      rx(4'h0, 8'h01);
      host.wr(4'h1, 8'h01);
      cyc(4);
      check(8'(irq), 8'h01);
      host.wr(4'h3, 8'h01);
      cyc(4);
      check(8'(irq), 8'h01);
      oc_comp <= 1'b0;
      cyc(6);
      check({7'h0, irq}, 8'h01);
      host.wr(4'h3, 8'h01);
      cyc(4);
      check({oc_flag, irq}, 8'h00);
      rx(4'h0, 8'h00);
      host.wr(4'h1, 8'h00);
      $display("test overcurrent done");
      // Init, then low to high with dead gap
      host.init_seq();
      rx(4'h6, 8'h40);
      host.cmd(3'h0, 3'h1);
      cyc(8);
      check(8'(lg), 8'h01);
      host.cmd(3'h1, 3'h0);
      n = 0;
      while (hg[0] !== 1'b1 && n < 60)
      begin
         cyc(1);
         n++;
      end
      check(8'(n > dt && n < 60), 8'h01);
      $display("test deadtime done");
      // Short desat is dropped; long one with shutdown off, then on
      cyc(30);
      desat <= 3'h1;
      cyc(50);
      desat <= 3'h0;
      cyc(10);
      rx(4'h0, 8'h00);
      host.wr(4'h1, 8'h02);
      for (int i = 0; i < 2; i++)
      begin
         host.wr(4'h2, i ? 8'h00 : 8'h01);
         desat <= 3'h1;
         cyc(130);
         desat <= 3'h0;
         check(8'(hg), i ? 8'h00 : 8'h01);
         check(8'(irq), 8'h01);
         rx(4'h0, i ? 8'h06 : 8'h02);
         host.wr(4'h3, 8'h0f);
         host.wr(4'h4, 8'h0f);
      end
      host.cmd(3'h0, 3'h0);
      host.cmd(3'h1, 3'h0);
      cyc(30);
      check(8'(hg), 8'h00);
      host.init_seq();
      host.cmd(3'h1, 3'h0);
      cyc(30);
      check(8'(hg), 8'h01);
      $display("test desaturation done");
      // Low side error on phase 1, high side error on phase 2
      host.wr(4'h1, 8'h04);
      for (int i = 0; i < 2; i++)
      begin
         force_m <= i ? 3'h4 : 3'h2;
         force_v <= i ? 3'h0 : 3'h2;
         host.cmd(i ? 3'h5 : 3'h1, i ? 3'h0 : 3'h2);
         cyc(60);
         rx(4'h0, 8'h04);
         check(8'(irq), 8'h01);
         force_m <= 3'h0;
         host.cmd(3'h0, 3'h0);
         cyc(6);
         host.wr(4'h4, 8'h0f);
         cyc(4);
         check(8'(irq), 8'h00);
         host.init_seq();
      end
      host.wr(4'h1, 8'h00);
      $display("test phase error done");
      // Undervoltage: short dip ignored, long one drives off
      gs_low <= 1'b1;
      cyc(30);
      gs_low <= 1'b0;
      cyc(10);
      rx(4'h0, 8'h00);
      host.cmd(3'h0, 3'h1);
      gs_low <= 1'b1;
      n = 0;
      while (ao === 3'h0 && n < 200)
      begin
         cyc(1);
         n++;
      end
      check({2'h0, hg, lg}, 8'h00);
      n = 0;
      while (ao !== 3'h0 && n < 50)
      begin
         cyc(1);
         n++;
      end
      check(8'(n >= UV_CYC - 1 && n <= UV_CYC + 1), 8'h01);
      check(8'(lg), 8'h00);
      rx(4'h0, 8'h08);
      gs_low <= 1'b0;
      cyc(10);
      check(8'(lg), 8'h01);
      check(8'(hoe), 8'h00);
      host.cmd(3'h0, 3'h0);
      cyc(10);
      check(8'(hoe[0]), 8'h01);
      $display("test undervoltage done");
      // Logic supply loss, then a second reset
      host.cmd(3'h0, 3'h7);
      cyc(8);
      check(8'(lg), 8'h07);
      supply_ok <= 1'b0;
      cyc(5);
      check({2'h0, hg, lg}, 8'h00);
      supply_ok <= 1'b1;
      reset_n_in <= 1'b0;
      cyc(3);
      reset_n_in <= 1'b1;
      rx(4'h0, 8'h00);
      cyc(2);
      $display("test hold-off done");
      tally_and_finish();
   end
endmodule // tb
